// ### fspc_ctrl.sv
// Flash security, protection, command checking and clock divider controller
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module fspc_ctrl
  import fspc_pkg::*;
(
  input  wire  logic        clk_i,
  input  wire  logic        rst_i,
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [7:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output var   logic [31:0] wb_dat_o,
  output var   logic        wb_ack_o,
  input  wire  logic        nv_valid_i,
  input  wire  logic [7:0]  nv_sec_byte_i,
  input  wire  logic [7:0]  nv_prot_byte_i,
  input  wire  logic        nv_dbl_fault_i,
  input  wire  logic        backdoor_ok_i,
  output var   logic        mem_req_o,
  output var   logic [1:0]  mem_op_o,
  output var   logic [17:0] mem_addr_o,
  output var   logic [63:0] mem_wdata_o,
  input  wire  logic        mem_done_i,
  input  wire  logic        mem_blank_i,
  input  wire  logic        mem_err_i,
  input  wire  logic        mem_uncorr_i,
  output var   logic        secured_o,
  output var   logic        backdoor_en_o,
  output var   logic        pf_read_invalid_o,
  output var   logic        div_tick_o
);
  import fspc_pkg::*;

  typedef struct packed {
    fspc_state_t       state;
    logic              ack;
    logic [31:0]       rdat;
    logic              command_complete_flag;
    logic              access_error_flag;
    logic              protection_violation_flag;
    logic              mgerr;
    logic              mgunc;
    logic [7:0]        clkdiv;
    logic [7:0]        sec;
    logic [7:0]        dfprot;
    logic [7:0]        pfprot;
    logic [2:0]        idx;
    logic [5:0][15:0]  cmd;
    logic [7:0]        otp_used;
    logic [5:0]        div_cnt;
    logic              tick;
    logic              mreq;
    logic [1:0]        mop;
    logic [17:0]       maddr;
    logic [63:0]       mdata;
    logic              secured;
    logic              bd_en;
    logic              rd_invalid;
  } fspc_regs_t;

  fspc_regs_t st_r;
  fspc_regs_t st_nxt;

  // Data-flash protected window test
  function automatic logic df_protected(input logic [17:0] a, input logic [7:0] prot);
    logic [5:0]  sz;
    logic [17:0] span;
    sz   = (prot[5:0] > DF_SIZE_CAP) ? DF_SIZE_CAP : prot[5:0];
    span = {7'h00, sz + 6'h01, 5'h00};
    return !prot[DP_OPEN] && (a >= DF_BASE) && (a < DF_BASE + span);
  endfunction

  // Program-flash protection: top region sized in 256-byte steps
  function automatic logic pf_protected(input logic [17:0] a, input logic [7:0] prot);
    logic [18:0] span;
    span = {4'h0, {1'b0, prot[5:0]} + 7'h01, 8'h00};
    return prot[7] && ({1'b0, a} >= (19'h40000 - span));
  endfunction

  logic        wr_req;
  logic        rd_sel;
  logic [7:0]  code;
  logic [17:0] gaddr;
  logic [2:0]  otp_idx;

  always_comb
  begin
    st_nxt   = st_r;
    wr_req   = wb_cyc_i && wb_stb_i && wb_we_i && !st_r.ack && wb_sel_i[0];
    rd_sel   = 1'b0;
    code     = st_r.cmd[IDX_CODE][15:8];
    gaddr    = {st_r.cmd[IDX_CODE][1:0], st_r.cmd[IDX_ADDR]};
    otp_idx  = st_r.cmd[IDX_ADDR][2:0];

    st_nxt.mreq = 1'b0;
    st_nxt.tick = 1'b0;

    // Timing base: tick every divider value plus one bus cycles
    if (st_r.div_cnt >= st_r.clkdiv[5:0])
    begin
      st_nxt.div_cnt = 6'h00;
      st_nxt.tick    = 1'b1;
    end
    else
    begin
      st_nxt.div_cnt = st_r.div_cnt + 6'h01;
    end

    // Bus: ack one cycle after the request, dropped the next cycle
    st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
    st_nxt.rdat = 32'h0000_0000;
    if (wb_adr_i == OFS_STATUS)
    begin
      st_nxt.rdat[7:0] = {st_r.command_complete_flag, 1'b0, st_r.access_error_flag, st_r.protection_violation_flag, 2'h0,
                          st_r.mgerr, st_r.mgunc};
    end
    else if (wb_adr_i == OFS_CLKDIV)
      st_nxt.rdat[7:0] = st_r.clkdiv;
    else if (wb_adr_i == OFS_SECURITY)
      st_nxt.rdat[7:0] = st_r.sec;
    else if (wb_adr_i == OFS_DFPROT)
      st_nxt.rdat[7:0] = {st_r.dfprot[7], 1'b0, st_r.dfprot[5:0]};
    else if (wb_adr_i == OFS_PFPROT)
      st_nxt.rdat[7:0] = {st_r.pfprot[7], 1'b0, st_r.pfprot[5:0]};
    else if (wb_adr_i == OFS_CMDIDX)
      st_nxt.rdat[2:0] = st_r.idx;
    else if (wb_adr_i == OFS_CMDDATA)
      rd_sel = 1'b1;
    if (rd_sel)
      st_nxt.rdat[15:0] = (st_r.idx <= IDX_PHRASE) ? st_r.cmd[st_r.idx] : 16'h0000;

    // Register writes
    if (wr_req && st_r.state != S_LOAD)
    begin
      if (wb_adr_i == OFS_STATUS)
      begin
        if (wb_dat_i[ST_ACCESS_ERROR_FLAG])
          st_nxt.access_error_flag = 1'b0;
        if (wb_dat_i[ST_PROTECTION_VIOLATION_FLAG])
          st_nxt.protection_violation_flag = 1'b0;
        // write one clears flag, starts command, only while no access error or protection violation flag is set
        if (wb_dat_i[ST_COMMAND_COMPLETE_FLAG] && st_r.command_complete_flag && !st_r.access_error_flag && !st_r.protection_violation_flag)
        begin
          st_nxt.command_complete_flag  = 1'b0;
          st_nxt.mgerr = 1'b0;
          st_nxt.mgunc = 1'b0;
          st_nxt.state = S_CHECK;
        end
      end
      else if (wb_adr_i == OFS_CLKDIV)
      begin
        st_nxt.clkdiv[CD_LOADED] = 1'b1;
        st_nxt.clkdiv[CD_LOCK]   = st_r.clkdiv[CD_LOCK] | wb_dat_i[CD_LOCK];
        if (!st_r.clkdiv[CD_LOCK])
          st_nxt.clkdiv[5:0] = wb_dat_i[5:0];
      end
      else if (wb_adr_i == OFS_DFPROT)
        st_nxt.dfprot = {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
      else if (wb_adr_i == OFS_PFPROT)
        st_nxt.pfprot = {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
      else if (wb_adr_i == OFS_CMDIDX && st_r.command_complete_flag)
        st_nxt.idx = wb_dat_i[2:0];
      else if (wb_adr_i == OFS_CMDDATA && st_r.command_complete_flag && st_r.idx <= IDX_PHRASE && wb_sel_i[1])
        st_nxt.cmd[st_r.idx] = wb_dat_i[15:0];
    end

    if (backdoor_ok_i && st_r.sec[7:6] == KEY_ENABLED && st_r.state != S_LOAD)
      st_nxt.sec[1:0] = SEC_UNLOCKED;

    case (st_r.state)
      S_LOAD:
      begin
        if (nv_valid_i)
        begin
          // fault leaves part secured, backdoor off
          st_nxt.sec = nv_dbl_fault_i ? SEC_FAULT_VAL : nv_sec_byte_i;
          st_nxt.dfprot = nv_dbl_fault_i ? DFPROT_FAULT_VAL
                                         : {nv_prot_byte_i[7], 1'b0, nv_prot_byte_i[5:0]};
          st_nxt.command_complete_flag  = 1'b1;
          st_nxt.state = S_IDLE;
        end
      end
      S_IDLE:
      begin
      end
      S_CHECK:
      begin
        st_nxt.state = S_IDLE;
        st_nxt.command_complete_flag  = 1'b1;
        st_nxt.mdata = {st_r.cmd[2], st_r.cmd[3], st_r.cmd[4], st_r.cmd[5]};
        st_nxt.maddr = gaddr;
        if (!st_r.clkdiv[CD_LOADED])
          st_nxt.access_error_flag = 1'b1;
        else if (code == CMD_PROG_PHRASE)
        begin
          if (st_r.idx != IDX_PHRASE || gaddr[2:0] != 3'h0 || gaddr < PF_BASE)
            st_nxt.access_error_flag = 1'b1;
          else if (pf_protected(gaddr, st_r.pfprot))
            st_nxt.protection_violation_flag = 1'b1;
          else
          begin
            st_nxt.command_complete_flag  = 1'b0;
            st_nxt.state = S_PROG;
            st_nxt.mreq  = 1'b1;
            st_nxt.mop   = OP_PROG;
          end
        end
        else if (code == CMD_PROG_ONCE)
        begin
          if (st_r.idx != IDX_PHRASE || st_r.cmd[IDX_ADDR] > OTP_LAST_IDX
              || st_r.otp_used[otp_idx])
            st_nxt.access_error_flag = 1'b1;
          else
          begin
            st_nxt.command_complete_flag       = 1'b0;
            st_nxt.state      = S_BLANK;
            st_nxt.mreq       = 1'b1;
            st_nxt.mop        = OP_BLANK;
            st_nxt.maddr      = OTP_BASE + {12'h000, otp_idx, 3'h0};
            st_nxt.rd_invalid = 1'b1;
          end
        end
        else if (code == CMD_PROG_DF)
        begin
          if (st_r.idx < IDX_DATA0 || gaddr[0] || gaddr < DF_BASE || gaddr > DF_END)
            st_nxt.access_error_flag = 1'b1;
          else if (df_protected(gaddr, st_r.dfprot))
            st_nxt.protection_violation_flag = 1'b1;
          else
          begin
            st_nxt.command_complete_flag  = 1'b0;
            st_nxt.state = S_PROG;
            st_nxt.mreq  = 1'b1;
            st_nxt.mop   = OP_PROG;
          end
        end
        else if (code == CMD_ERASE_DFSEC || code == CMD_ERASE_DFBLK)
        begin
          if ((code == CMD_ERASE_DFSEC) ? (st_r.idx != IDX_ADDR || gaddr < DF_BASE
              || gaddr > DF_END) : (st_r.idx != IDX_CODE))
            st_nxt.access_error_flag = 1'b1;
          // any protected sector blocks block erase
          else if (code == CMD_ERASE_DFBLK && !st_r.dfprot[DP_OPEN])
            st_nxt.protection_violation_flag = 1'b1;
          else if (code == CMD_ERASE_DFSEC && df_protected(gaddr, st_r.dfprot))
            st_nxt.protection_violation_flag = 1'b1;
          else
          begin
            st_nxt.command_complete_flag  = 1'b0;
            st_nxt.state = S_ERASE;
            st_nxt.mreq  = 1'b1;
            st_nxt.mop   = OP_ERASE;
            st_nxt.maddr = (code == CMD_ERASE_DFBLK) ? DF_BASE : gaddr;
          end
        end
        else
          st_nxt.access_error_flag = 1'b1;
      end
      S_BLANK:
      begin
        if (mem_done_i)
        begin
          if (!mem_blank_i)
          begin
            st_nxt.access_error_flag     = 1'b1;
            st_nxt.otp_used[otp_idx] = 1'b1;
            st_nxt.command_complete_flag       = 1'b1;
            st_nxt.rd_invalid = 1'b0;
            st_nxt.state      = S_IDLE;
          end
          else
          begin
            st_nxt.state = S_PROG;
            st_nxt.mreq  = 1'b1;
            st_nxt.mop   = OP_PROG;
          end
        end
      end
      S_PROG:
      begin
        if (mem_done_i)
        begin
          st_nxt.state = S_VERIFY;
          st_nxt.mreq  = 1'b1;
          st_nxt.mop   = OP_VERIFY;
        end
      end
      S_VERIFY, S_ERASE:
      begin
        if (mem_done_i)
        begin
          st_nxt.mgerr = mem_err_i;
          st_nxt.mgunc = mem_uncorr_i;
          if (st_r.rd_invalid)
            st_nxt.otp_used[otp_idx] = 1'b1;
          st_nxt.command_complete_flag       = 1'b1;
          st_nxt.rd_invalid = 1'b0;
          st_nxt.state      = S_IDLE;
        end
      end
      default:
        st_nxt.state = S_IDLE;
    endcase

    st_nxt.secured = (st_nxt.sec[1:0] != SEC_UNLOCKED);
    st_nxt.bd_en   = (st_nxt.sec[7:6] == KEY_ENABLED);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r          <= '0;
      st_r.state    <= S_LOAD;
      st_r.clkdiv   <= CLKDIV_RST;
      st_r.pfprot   <= PFPROT_RST;
      st_r.sec      <= SEC_FAULT_VAL;
      st_r.dfprot   <= DFPROT_FAULT_VAL;
      st_r.secured  <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o          = st_r.ack;
  assign wb_dat_o          = st_r.rdat;
  assign mem_req_o         = st_r.mreq;
  assign mem_op_o          = st_r.mop;
  assign mem_addr_o        = st_r.maddr;
  assign mem_wdata_o       = st_r.mdata;
  assign secured_o         = st_r.secured;
  assign backdoor_en_o     = st_r.bd_en;
  assign pf_read_invalid_o = st_r.rd_invalid;
  assign div_tick_o        = st_r.tick;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_status_write(logic [7:0] bits);
    wr_req && wb_adr_i == OFS_STATUS && (wb_dat_i[7:0] & bits) != 8'h00;
  endsequence

  sequence s_check(logic [7:0] c);
    st_r.state == S_CHECK && code == c && st_r.clkdiv[CD_LOADED];
  endsequence

  property p_fault_sec;
    st_r.state == S_LOAD && nv_valid_i && nv_dbl_fault_i |=> st_r.sec == 8'hff && !backdoor_en_o;
  endproperty
  a_fault_sec: assert property (p_fault_sec) else $error("security not forced on fault");

  property p_gate;
    backdoor_en_o == (st_r.sec[7:6] == 2'h2);
  endproperty
  a_gate: assert property (p_gate) else $error("backdoor gate decode wrong");

  property p_lock;
    secured_o == (st_r.sec[1:0] != 2'h2);
  endproperty
  a_lock: assert property (p_lock) else $error("lock state decode wrong");

  property p_index;
    s_check(CMD_PROG_PHRASE) ##0 st_r.idx != 3'h5 |=> st_r.access_error_flag && st_r.command_complete_flag;
  endproperty
  a_index: assert property (p_index) else $error("bad index not flagged");

  property p_align;
    s_check(CMD_PROG_PHRASE) ##0 gaddr[2:0] != 3'h0 |=> st_r.access_error_flag && st_r.state == S_IDLE;
  endproperty
  a_align: assert property (p_align) else $error("misaligned phrase not flagged");

  property p_loaded;
    wr_req && wb_adr_i == OFS_CLKDIV && st_r.state != S_LOAD |=> st_r.clkdiv[7];
  endproperty
  a_loaded: assert property (p_loaded) else $error("divider written bit not set");

  property p_div_lock;
    st_r.clkdiv[6] |=> st_r.clkdiv[6] && $stable(st_r.clkdiv[5:0]);
  endproperty
  a_div_lock: assert property (p_div_lock) else $error("locked divider changed");

  property p_launch_hold;
    st_r.state inside {S_CHECK, S_BLANK, S_PROG, S_VERIFY, S_ERASE} |-> !st_r.command_complete_flag;
  endproperty
  a_launch_hold: assert property (p_launch_hold) else $error("complete flag set while busy");

  property p_blocked;
    s_status_write(8'h80) ##0 st_r.access_error_flag && st_r.command_complete_flag |=> st_r.command_complete_flag && st_r.state == S_IDLE;
  endproperty
  a_blocked: assert property (p_blocked) else $error("launch taken under access error");

  property p_range;
    !st_r.dfprot[7] && st_r.dfprot[5:0] >= 6'h2f |-> df_protected(18'h009ff - 18'h0 + 18'h0
      - 18'h00400 + 18'h00400, st_r.dfprot) == (18'h009ff <= 18'h009ff)
      && !df_protected(18'h00a00, st_r.dfprot) && df_protected(18'h00400, st_r.dfprot);
  endproperty
  a_range: assert property (p_range) else $error("capped protection range wrong");

  property p_blk_erase;
    s_check(CMD_ERASE_DFBLK) ##0 st_r.idx == 3'h0 && !st_r.dfprot[7] |=> st_r.protection_violation_flag ##1 st_r.command_complete_flag;
  endproperty
  a_blk_erase: assert property (p_blk_erase) else $error("block erase not refused");

endmodule // fspc_ctrl

`default_nettype wire

// ### fspc_pkg.sv
// Constants, register map and types of the flash security and protection controller
package fspc_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CLKDIV   = 8'h04;
  localparam logic [7:0] OFS_SECURITY = 8'h08;
  localparam logic [7:0] OFS_DFPROT   = 8'h0c;
  localparam logic [7:0] OFS_PFPROT   = 8'h10;
  localparam logic [7:0] OFS_CMDIDX   = 8'h14;
  localparam logic [7:0] OFS_CMDDATA  = 8'h18;

  // Status register bit positions
  localparam int ST_COMMAND_COMPLETE_FLAG   = 7;
  localparam int ST_ACCESS_ERROR_FLAG = 5;
  localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
  localparam int ST_MGERR  = 1;
  localparam int ST_MGUNC  = 0;

  // Clock divider register fields
  localparam int CD_LOADED = 7;
  localparam int CD_LOCK   = 6;

  // Data-flash protection register fields
  localparam int DP_OPEN = 7;

  // Reset values
  localparam logic [7:0] SEC_FAULT_VAL    = 8'hff;
  localparam logic [7:0] DFPROT_FAULT_VAL = 8'h3f;
  localparam logic [7:0] CLKDIV_RST       = 8'h00;
  localparam logic [7:0] PFPROT_RST       = 8'h00;

  // Field encodings
  localparam logic [1:0] KEY_ENABLED  = 2'h2;
  localparam logic [1:0] SEC_UNLOCKED = 2'h2;

  // Nonvolatile byte addresses read during the reset sequence
  localparam logic [17:0] NV_SEC_ADDR  = 18'h3ff0f;
  localparam logic [17:0] NV_PROT_ADDR = 18'h3ff0d;

  // Memory map
  localparam logic [17:0] PF_BASE      = 18'h3c000;
  localparam logic [17:0] DF_BASE      = 18'h00400;
  localparam logic [17:0] DF_END       = 18'h005ff;
  localparam logic [17:0] OTP_BASE     = 18'h040c0;
  localparam logic [5:0]  DF_SIZE_CAP  = 6'h2f;
  localparam logic [15:0] OTP_LAST_IDX = 16'h0007;

  // Command codes
  localparam logic [7:0] CMD_PROG_PHRASE = 8'h06;
  localparam logic [7:0] CMD_PROG_ONCE   = 8'h07;
  localparam logic [7:0] CMD_ERASE_DFBLK = 8'h08;
  localparam logic [7:0] CMD_PROG_DF     = 8'h11;
  localparam logic [7:0] CMD_ERASE_DFSEC = 8'h12;

  // Parameter indexes
  localparam logic [2:0] IDX_PHRASE = 3'h5;
  localparam logic [2:0] IDX_DATA0  = 3'h2;
  localparam logic [2:0] IDX_ADDR   = 3'h1;
  localparam logic [2:0] IDX_CODE   = 3'h0;

  // Array operations
  localparam logic [1:0] OP_BLANK  = 2'h0;
  localparam logic [1:0] OP_PROG   = 2'h1;
  localparam logic [1:0] OP_VERIFY = 2'h2;
  localparam logic [1:0] OP_ERASE  = 2'h3;

  typedef enum logic [2:0] {
    S_LOAD   = 3'b000,
    S_IDLE   = 3'b001,
    S_CHECK  = 3'b010,
    S_BLANK  = 3'b011,
    S_PROG   = 3'b100,
    S_VERIFY = 3'b101,
    S_ERASE  = 3'b110
  } fspc_state_t;

endpackage

// ### test_fspc_ctrl.sv
// Self-checking bench for the flash security and protection controller
`timescale 1ns/1ps
`default_nettype none
module test_fspc_ctrl;
  import fspc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        nv_valid_i = 1'b0;
  logic [7:0]  nv_sec_byte_i = 8'h00;
  logic [7:0]  nv_prot_byte_i = 8'h00;
  logic        nv_dbl_fault_i = 1'b0;
  logic        backdoor_ok_i = 1'b0;
  logic        mem_req_o;
  logic [1:0]  mem_op_o;
  logic [17:0] mem_addr_o;
  logic [63:0] mem_wdata_o;
  logic        mem_done_i = 1'b0;
  logic        mem_blank_i = 1'b0;
  logic        mem_err_i = 1'b0;
  logic        mem_uncorr_i = 1'b0;
  logic        secured_o;
  logic        backdoor_en_o;
  logic        pf_read_invalid_o;
  logic        div_tick_o;
  int          err_total = 0;
  int          compares = 0;
  int          req_cnt = 0;
  logic [31:0] rd;
  localparam logic [63:0] PHRASE = 64'ha002a003a004a005;

  fspc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nv_valid_i(nv_valid_i),
    .nv_sec_byte_i(nv_sec_byte_i), .nv_prot_byte_i(nv_prot_byte_i),
    .nv_dbl_fault_i(nv_dbl_fault_i), .backdoor_ok_i(backdoor_ok_i), .mem_req_o(mem_req_o),
    .mem_op_o(mem_op_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_done_i(mem_done_i), .mem_blank_i(mem_blank_i), .mem_err_i(mem_err_i),
    .mem_uncorr_i(mem_uncorr_i), .secured_o(secured_o), .backdoor_en_o(backdoor_en_o),
    .pf_read_invalid_o(pf_read_invalid_o), .div_tick_o(div_tick_o));

  always #25 clk_i = ~clk_i;
  // Array requests seen, to prove refusals never reach the array
  always @(posedge clk_i)
    if (mem_req_o === 1'b1) req_cnt <= req_cnt + 1;

  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // One classic cycle; ack and data are the values sampled at the edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    chk(wb_ack_o, 1'b1, "bus ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string m);
    wb(1'b0, a, 32'h0);
    chk(rd, {24'h0, exp}, m);
  endtask

  task automatic hold_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic load_nv(input logic [7:0] s, input logic [7:0] p, input logic f);
    @(posedge clk_i);
    nv_sec_byte_i  <= s;
    nv_prot_byte_i <= p;
    nv_dbl_fault_i <= f;
    nv_valid_i     <= 1'b1;
    @(posedge clk_i);
    nv_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic boot(input logic [7:0] s, input logic [7:0] p);
    hold_reset();
    load_nv(s, p, 1'b0);
  endtask

  task automatic ticks(input int exp);
    int c;
    c = 0;
    repeat (60)
    begin
      @(posedge clk_i);
      if (div_tick_o === 1'b1) c++;
    end
    chk(c, exp, "divider tick count");
  endtask

  task automatic cmd(input logic [7:0] code, input logic [17:0] a, input int last);
    wb(1'b1, OFS_CMDIDX, 32'h0);
    wb(1'b1, OFS_CMDDATA, {16'h0, code, 6'h00, a[17:16]});
    wb(1'b1, OFS_CMDIDX, 32'h1);
    wb(1'b1, OFS_CMDDATA, {16'h0, a[15:0]});
    for (int i = 2; i <= last; i++)
    begin
      wb(1'b1, OFS_CMDIDX, 32'(i));
      wb(1'b1, OFS_CMDDATA, 32'ha000 + 32'(i));
    end
    wb(1'b1, OFS_CMDIDX, 32'(last));
    wb(1'b1, OFS_STATUS, 32'h80);
  endtask

  task automatic wait_done(input logic [7:0] exp, input string m);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (rd[ST_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 100);
    chk(rd, {24'h0, exp}, m);
  endtask

  // Answers one array operation; the array waits while peek reads status
  task automatic mem_step(input logic [1:0] op, input logic [17:0] a, input logic b,
                          input logic e, input logic u, input logic w, input logic peek);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (mem_req_o !== 1'b1 && n < 200);
    chk(mem_op_o, op, "array op");
    chk(mem_addr_o, a, "array address");
    if (w) chk(mem_wdata_o, PHRASE, "phrase data");
    if (peek)
    begin
      chk(pf_read_invalid_o, 1'b1, "flash reads marked invalid");
      wb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[ST_COMMAND_COMPLETE_FLAG], 1'b0, "complete flag during command");
    end
    @(posedge clk_i);
    mem_done_i   <= 1'b1;
    mem_blank_i  <= b;
    mem_err_i    <= e;
    mem_uncorr_i <= u;
    @(posedge clk_i);
    mem_done_i <= 1'b0;
  endtask

  task automatic prog(input logic [17:0] a, input logic w, input logic e, input logic u,
                      input logic [7:0] exp);
    mem_step(OP_PROG, a, 1'b0, 1'b0, 1'b0, w, 1'b0);
    mem_step(OP_VERIFY, a, 1'b0, e, u, 1'b0, 1'b0);
    wait_done(exp, "status after program");
  endtask

  task automatic refused(input logic [7:0] code, input logic [17:0] a, input int last,
                         input logic [7:0] exp);
    int c;
    c = req_cnt;
    cmd(code, a, last);
    wait_done(exp, "refused command status");
    chk(req_cnt, c, "refused command reached array");
    wb(1'b1, OFS_STATUS, 32'h30);
  endtask

  task automatic t_reset;
    hold_reset();
    chk(secured_o, 1'b1, "secured after reset");
    chk(backdoor_en_o, 1'b0, "backdoor after reset");
    rd_chk(OFS_STATUS, 8'h00, "status before load");
    load_nv(8'hd6, 8'h85, 1'b1);
    rd_chk(OFS_SECURITY, 8'hff, "security after fault");
    chk(backdoor_en_o, 1'b0, "backdoor after fault");
    rd_chk(OFS_DFPROT, 8'h3f, "protection after fault");
    boot(8'h96, 8'h85);
    rd_chk(OFS_SECURITY, 8'h96, "security byte loaded");
    rd_chk(OFS_DFPROT, 8'h85, "protection byte loaded");
    rd_chk(OFS_STATUS, 8'h80, "status after load");
    wb(1'b1, OFS_SECURITY, 32'h0);
    rd_chk(OFS_SECURITY, 8'h96, "security is read only");
    rd_chk(8'hfc, 8'h00, "unmapped address");
  endtask

  task automatic t_decode;
    for (int i = 0; i < 4; i++)
    begin
      boot({2'(i), 4'h0, 2'(i)}, 8'h00);
      chk(backdoor_en_o, 1'(i == 2), "gate decode");
      chk(secured_o, 1'(i != 2), "lock decode");
    end
  endtask

  task automatic t_backdoor(input logic [7:0] s, input logic [7:0] exp);
    boot(s, 8'h00);
    @(posedge clk_i);
    backdoor_ok_i <= 1'b1;
    @(posedge clk_i);
    backdoor_ok_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(secured_o, 1'(exp[1:0] != 2'h2), "secured after key");
    rd_chk(OFS_SECURITY, exp, "lock field after key");
  endtask

  task automatic t_divider;
    boot(8'h00, 8'h00);
    rd_chk(OFS_CLKDIV, 8'h00, "divider unwritten");
    ticks(60);
    refused(CMD_PROG_PHRASE, 18'h3c000, 5, 8'ha0);
    wb(1'b1, OFS_CLKDIV, 32'h45);
    rd_chk(OFS_CLKDIV, 8'hc5, "divider written and locked");
    ticks(10);
    wb(1'b1, OFS_CLKDIV, 32'h13);
    rd_chk(OFS_CLKDIV, 8'hc5, "locked divider kept");
    ticks(10);
    boot(8'h00, 8'h00);
    rd_chk(OFS_CLKDIV, 8'h00, "reset clears lock");
  endtask

  task automatic t_phrase;
    int c;
    boot(8'h00, 8'h00);
    wb(1'b1, OFS_CLKDIV, 32'h13);
    refused(CMD_PROG_PHRASE, 18'h3c000, 4, 8'ha0);
    refused(CMD_PROG_PHRASE, 18'h3c004, 5, 8'ha0);
    wb(1'b1, OFS_PFPROT, 32'h80);
    refused(CMD_PROG_PHRASE, 18'h3fff8, 5, 8'h90);
    cmd(CMD_PROG_PHRASE, 18'h3c000, 4);
    wait_done(8'ha0, "error before blocked launch");
    c = req_cnt;
    wb(1'b1, OFS_STATUS, 32'h80);
    rd_chk(OFS_STATUS, 8'ha0, "launch blocked by error");
    chk(req_cnt, c, "blocked launch reached array");
    wb(1'b1, OFS_STATUS, 32'h30);
    cmd(CMD_PROG_PHRASE, 18'h3c010, 5);
    prog(18'h3c010, 1'b1, 1'b1, 1'b0, 8'h82);
    cmd(CMD_PROG_PHRASE, 18'h3c018, 5);
    prog(18'h3c018, 1'b1, 1'b1, 1'b1, 8'h83);
  endtask

  task automatic t_once;
    boot(8'h00, 8'h00);
    wb(1'b1, OFS_CLKDIV, 32'h13);
    cmd(CMD_PROG_ONCE, 18'h00003, 5);
    mem_step(OP_BLANK, 18'h040d8, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    prog(18'h040d8, 1'b1, 1'b0, 1'b0, 8'h80);
    chk(pf_read_invalid_o, 1'b0, "flash reads valid again");
    refused(CMD_PROG_ONCE, 18'h00003, 5, 8'ha0);
    refused(CMD_PROG_ONCE, 18'h00008, 5, 8'ha0);
    cmd(CMD_PROG_ONCE, 18'h00007, 5);
    mem_step(OP_BLANK, 18'h040f8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_done(8'ha0, "non-blank phrase refused");
  endtask

  task automatic t_dflash;
    boot(8'h00, 8'h02);
    wb(1'b1, OFS_CLKDIV, 32'h13);
    refused(CMD_PROG_DF, 18'h0045e, 2, 8'h90);
    cmd(CMD_PROG_DF, 18'h00460, 2);
    prog(18'h00460, 1'b0, 1'b0, 1'b0, 8'h80);
    refused(CMD_ERASE_DFBLK, 18'h00400, 0, 8'h90);
    wb(1'b1, OFS_DFPROT, 32'h2f);
    refused(CMD_PROG_DF, 18'h005fe, 2, 8'h90);
    wb(1'b1, OFS_DFPROT, 32'haf);
    cmd(CMD_PROG_DF, 18'h00440, 2);
    prog(18'h00440, 1'b0, 1'b0, 1'b0, 8'h80);
  endtask

  initial
  begin
    t_reset();
    t_decode();
    t_backdoor(8'h80, 8'h82);
    t_backdoor(8'h40, 8'h40);
    t_divider();
    t_phrase();
    t_once();
    t_dflash();
    stop_test();
  end

  // Whole run needs about a thousand cycles
  initial
  begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // test_fspc_ctrl
`default_nettype wire
